// ### verilog/ctu_pkg.sv
// Package for the charge time unit edge control block: register offsets, field positions and reset values.
// Assumes a 32-bit APB register bus with one register per aligned word.
package ctu_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTU_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CTU_REV_OFFSET = 8'h04;
    localparam int CTU_ADDR_W = 8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTU_UNIT_ENABLE_BIT = 15;
    localparam int CTU_IDLE_STOP_BIT = 13;
    localparam int CTU_DELAY_GEN_BIT = 12;
    localparam int CTU_EDGE_PASS_BIT = 11;
    localparam int CTU_EDGE_ORDER_BIT = 10;
    localparam int CTU_SRC_GROUND_BIT = 9;
    localparam int CTU_TRIG_BIT = 8;
    localparam int CTU_TRIM_LSB = 2;
    localparam int CTU_TRIM_W = 6;
    localparam int CTU_RANGE_LSB = 0;
    localparam int CTU_RANGE_W = 2;
    // Bit 14 is unimplemented and reads as zero.
    localparam logic [15:0] CTU_CTRL_WMASK = 16'hBFFF;
    localparam logic [15:0] CTU_CTRL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Revision register
    // ------------------------------------------------------------
    localparam int CTU_REV_W = 24;
    localparam int CTU_MINOR_REV_W = 4;
    // Arbitrary neutral value.
    localparam logic [3:0] CTU_MINOR_REV_DEFAULT = 4'h1;
endpackage

// ### verilog/ctu_edge_ctrl.sv
// Control register logic for the charge time unit: edge gating, edge ordering, delay enable and trigger.
// Assumes an APB master on clk; edge inputs come from pins and are synchronised here.
// Functional notes
// - Edge delay generation runs only while the delay enable bit is set.
// - Edge events pass to measurement only while the edge pass bit is set.
// - With ordering enabled, edge two is accepted only after edge one occurred; here it is also accepted in the same cycle as edge one.
// - Trigger output is driven only while the trigger enable bit is set.
// - Six-bit current trim in bits 7..2; top bit set means negative change.
// - Four-bit read-only minor revision in bits 3..0; writes ignored.
// - Revision bits 23..4 read as zero.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module ctu_edge_ctrl #(
    parameter logic [3:0] MINOR_REV = ctu_pkg::CTU_MINOR_REV_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ctu_pkg::CTU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Edge pins and trigger source
    input wire logic edge1_in,
    input wire logic edge2_in,
    input wire logic trig_src,
    // Outputs toward the measurement logic
    output logic edge1_evt,
    output logic edge2_evt,
    output logic delay_gen_on,
    output logic trig_out,
    output logic unit_enable,
    output logic idle_stop_select,
    output logic source_ground_control,
    output logic [ctu_pkg::CTU_TRIM_W-1:0] current_trim,
    output logic [ctu_pkg::CTU_RANGE_W-1:0] current_range_select
);
    import ctu_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    // Edge pins are gathered into one vector so that their synchronisers are one loop.
    localparam int EDGE_N = 2;
    wire [EDGE_N-1:0] edge_pins;
    wire [EDGE_N-1:0] pin_rise;
    logic [1:0] tr_sync_r, tr_sync_nxt;
    logic first_seen_r, first_seen_nxt;
    logic e1_evt_r, e1_evt_nxt;
    logic e2_evt_r, e2_evt_nxt;
    logic trig_r, trig_nxt;
    logic dly_r, dly_nxt;
    logic hit_ctrl, hit_rev, acc;
    logic e1_rise, e2_rise, e2_ok;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // The slave answers in the second access cycle; pready is registered so
    // it rises one cycle into the access phase and drops right after.
    always_comb begin
        hit_ctrl = (paddr == CTU_CTRL_OFFSET);
        hit_rev = (paddr == CTU_REV_OFFSET);
        acc = psel && penable && !pready_r;
        ctrl_nxt = ctrl_r;
        prdata_nxt = prdata_r;
        pready_nxt = acc;
        pslverr_nxt = acc && !(hit_ctrl || hit_rev);
        if (acc && pwrite && hit_ctrl) begin
            ctrl_nxt = pwdata[15:0] & CTU_CTRL_WMASK;
        end
        if (acc && !pwrite) begin
            if (hit_ctrl) begin
                prdata_nxt = {16'h0000, ctrl_r};
            end else if (hit_rev) begin
                prdata_nxt = {8'h00, 20'h00000, MINOR_REV};
            end else begin
                prdata_nxt = 32'h00000000;
            end
        end
    end

    // Unmapped addresses and the read-only revision register leave the control
    // word untouched; only a decoded control write loads it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= CTU_CTRL_RESET;
            prdata_r <= 32'h00000000;
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Each edge pin passes two flip-flops before anything reads it; a third
    // stage keeps the previous settled level, so a rise is found without ever
    // looking at the possibly metastable first stage.
    assign edge_pins = {edge2_in, edge1_in};

    for (genvar g = 0; g < EDGE_N; g++) begin : g_edge_sync
        logic [2:0] sync_r, sync_nxt;

        always_comb begin
            sync_nxt = {sync_r[1:0], edge_pins[g]};
        end

        always_ff @(posedge clk) begin
            if (!rstn) begin
                sync_r <= 3'h0;
            end else begin
                sync_r <= sync_nxt;
            end
        end

        // Settled level from the second stage against the previous one from the third.
        assign pin_rise[g] = sync_r[1] && !sync_r[2];
    end

    // The trigger source is a level, not an edge, so two stages are enough.
    always_comb begin
        tr_sync_nxt = {tr_sync_r[0], trig_src};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tr_sync_r <= 2'h0;
        end else begin
            tr_sync_r <= tr_sync_nxt;
        end
    end

    // ------------------------------------------------------------
    // Edge acceptance
    // ------------------------------------------------------------
    // The order latch remembers an accepted first edge until a second edge
    // consumes it. Both edges in one cycle count as a complete sequence, so the
    // latch ends up clear and the next second edge needs a fresh first edge.
    always_comb begin
        e1_rise = pin_rise[0] && ctrl_r[CTU_EDGE_PASS_BIT];
        e2_ok = !ctrl_r[CTU_EDGE_ORDER_BIT] || first_seen_r || e1_rise;
        e2_rise = pin_rise[1] && ctrl_r[CTU_EDGE_PASS_BIT] && e2_ok;
        first_seen_nxt = first_seen_r;
        if (!ctrl_r[CTU_EDGE_ORDER_BIT] || !ctrl_r[CTU_EDGE_PASS_BIT]) begin
            first_seen_nxt = 1'h0;
        end else if (e2_rise) begin
            first_seen_nxt = 1'h0;
        end else if (e1_rise) begin
            first_seen_nxt = 1'h1;
        end
        e1_evt_nxt = e1_rise;
        e2_evt_nxt = e2_rise;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            first_seen_r <= 1'h0;
            e1_evt_r <= 1'h0;
            e2_evt_r <= 1'h0;
        end else begin
            first_seen_r <= first_seen_nxt;
            e1_evt_r <= e1_evt_nxt;
            e2_evt_r <= e2_evt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Delay gate and trigger
    // ------------------------------------------------------------
    // The delay generator and the trigger driver sit outside this block; these
    // flops are their gates, registered so that a control write never glitches them.
    always_comb begin
        trig_nxt = ctrl_r[CTU_TRIG_BIT] && tr_sync_r[1];
        dly_nxt = ctrl_r[CTU_DELAY_GEN_BIT];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trig_r <= 1'h0;
            dly_r <= 1'h0;
        end else begin
            trig_r <= trig_nxt;
            dly_r <= dly_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Fields that only steer the analog source leave straight from the control
    // register, which is itself a bank of flip-flops, so no extra stage is added.
    // A change therefore reaches the source one cycle before the gated outputs.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign edge1_evt = e1_evt_r;
    assign edge2_evt = e2_evt_r;
    assign delay_gen_on = dly_r;
    assign trig_out = trig_r;
    assign unit_enable = ctrl_r[CTU_UNIT_ENABLE_BIT];
    assign idle_stop_select = ctrl_r[CTU_IDLE_STOP_BIT];
    assign source_ground_control = ctrl_r[CTU_SRC_GROUND_BIT];
    assign current_trim = ctrl_r[CTU_TRIM_LSB +: CTU_TRIM_W];
    assign current_range_select = ctrl_r[CTU_RANGE_LSB +: CTU_RANGE_W];
endmodule

// ### verification/ctu_checker.sv
// Concurrent checks on the control block's APB answer and control outputs.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ps
module ctu_checker import ctu_pkg::*; #(
    parameter logic [3:0] MINOR_REV = CTU_MINOR_REV_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CTU_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Control outputs
    input wire logic edge1_evt,
    input wire logic edge2_evt,
    input wire logic delay_gen_on,
    input wire logic trig_out,
    input wire logic [CTU_TRIM_W-1:0] current_trim
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire done = psel && penable && pready;
    wire wr = done && pwrite && paddr == CTU_CTRL_OFFSET;
    a_delay_gen_bit: assert property (wr |=> delay_gen_on == $past(pwdata[12])) else $error("delay gate wrong");
    a_edge_blocked: assert property (wr && !pwdata[11] |-> ##2 (!edge1_evt && !edge2_evt) [*3])
        else $error("edge passed while blocked");
    a_trig_gated: assert property (wr && !pwdata[8] |-> ##2 !trig_out) else $error("trigger not gated");
    a_trim_field: assert property (wr |=> current_trim == $past(pwdata[7:2])) else $error("trim wrong");
    a_rev_value: assert property (done && !pwrite && paddr == CTU_REV_OFFSET |-> prdata == {28'h0, MINOR_REV})
        else $error("revision read wrong");
    a_reset_clear: assert property ($rose(rstn) |-> !trig_out && !delay_gen_on && current_trim == 6'h00)
        else $error("outputs not cleared");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_unmapped_err: assert property (pready && paddr > CTU_REV_OFFSET |-> pslverr) else $error("no error");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind ctu_edge_ctrl ctu_checker #(
    .MINOR_REV(MINOR_REV)
) i_ctu_checker (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .edge1_evt(edge1_evt),
    .edge2_evt(edge2_evt),
    .delay_gen_on(delay_gen_on),
    .trig_out(trig_out),
    .current_trim(current_trim)
);

// ### verification/tb_top.sv
// Bench for the control block: APB register access, edge gating and ordering, trigger gate.
// Drives every input itself; the checker is bound in.
`timescale 1ns/1ps
module tb_top;
    import ctu_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, edge1_in = 0, edge2_in = 0, trig_src = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, edge1_evt, edge2_evt, delay_gen_on, trig_out;
    logic [5:0] current_trim;
    logic unit_enable, idle_stop_select, source_ground_control;
    logic [1:0] current_range_select;
    logic [5:0] tv [4] = '{6'h1F, 6'h00, 6'h20, 6'h21};
    int mismatches = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    ctu_edge_ctrl #(.MINOR_REV(4'h6)) i_ctu_edge_ctrl (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .edge1_in, .edge2_in, .trig_src, .edge1_evt, .edge2_evt, .delay_gen_on,
        .trig_out, .unit_enable(unit_enable), .idle_stop_select(idle_stop_select),
        .source_ground_control(source_ground_control), .current_trim,
        .current_range_select(current_range_select));
    task chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task close_out;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Outputs are sampled two edges after the answer so that register updates have landed.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        if (pready !== 1'h1) begin
            chk("apb timeout", 1, 0);
            close_out();
        end
        repeat (2) @(posedge clk);
    endtask
    task edge_try(input bit two, input logic exp);
        logic seen;
        seen = 0;
        if (two) edge2_in <= 1; else edge1_in <= 1;
        repeat (8) begin
            @(posedge clk);
            seen |= two ? edge2_evt : edge1_evt;
        end
        {edge1_in, edge2_in} <= 2'b00;
        @(posedge clk);
        chk("edge event", exp, seen);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        apb(0, CTU_CTRL_OFFSET, 0); chk("ctrl reset", 0, rd);
        trig_src <= 1;
        foreach (tv[i]) begin
            apb(1, CTU_CTRL_OFFSET, {24'h19, tv[i], 2'h0});
            chk("trim", tv[i], current_trim);
            chk("delay gate", 1, delay_gen_on);
            chk("trigger", 1, trig_out);
            apb(0, CTU_CTRL_OFFSET, 0); chk("ctrl read", {24'h19, tv[i], 2'h0}, rd);
        end
        apb(1, CTU_CTRL_OFFSET, 32'hFFFF_FFFF);
        chk("unit enable", 1, unit_enable);
        chk("idle stop", 1, idle_stop_select);
        chk("source ground", 1, source_ground_control);
        chk("range select", 3, current_range_select);
        apb(1, 8'h10, 0); chk("unmapped write error", 1, err);
        apb(0, CTU_CTRL_OFFSET, 0); chk("ctrl masked", 32'h0000_BFFF, rd);
        apb(1, CTU_CTRL_OFFSET, 0); chk("delay off", 0, delay_gen_on);
        chk("trigger off", 0, trig_out);
        chk("unit off", 0, unit_enable);
        chk("range off", 0, current_range_select);
        edge_try(0, 0);
        apb(1, CTU_CTRL_OFFSET, 32'h0800);
        edge_try(0, 1);
        edge_try(1, 1);
        apb(1, CTU_CTRL_OFFSET, 32'h0C00);
        edge_try(1, 0); edge_try(0, 1); edge_try(1, 1); edge_try(1, 0);
        apb(1, CTU_REV_OFFSET, 32'hFFFF_FFFF);
        apb(0, CTU_REV_OFFSET, 0); chk("revision", 32'h6, rd);
        apb(0, 8'h10, 0); chk("unmapped error", 1, err);
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        apb(0, CTU_CTRL_OFFSET, 0); chk("ctrl second reset", 0, rd);
        chk("trigger after reset", 0, trig_out);
        chk("delay after reset", 0, delay_gen_on);
        close_out();
    end
endmodule
